// File: verilog/osr_row_map_soft_scroll.sv
// Row addressing through the scroll map, with soft and hard scroll control
`timescale 1ns/10ps
`default_nettype none
// Operation
// - One static region on the main row counter and one scroll region, never overlapping.
// - Map index is main row outside scroll region, scroll row counter inside.
// - Inside the visible scroll region the map text enable flag is ignored.
// - Rows pushed past vertical sync stop output as if the frame finished.
// - Visible height beyond the allocated rows wraps the scroll counter, repeating rows.
// - While soft scrolling, first scroll row start line count drops once per frame.
// - At count zero, scroll row counter increments and line count reloads to twelve.
// - Writing one to the start bit scrolls; hardware clears it after one row.
// - Writing zero stops soft scroll and hard scrolls the region up one row.
// - Area enable resets to zero; when one, area position, height, range apply.
// - Four-bit top field places scroll region at row 0 to 15 of text area.
// - Four-bit height field plus one gives visible region rows, 1 to 16.
// - Writing the range register loads scroll counter with start row: a hard scroll.
// - Start row written during soft scroll is applied once that scroll step ends.
// - Scroll range bounded by four-bit start and stop row numbers, 0 to 15.
// - Scroll map is sixteen 12-bit words at byte addresses 8000H to 801FH.
// - Map word: bit 11 text enable, bit 10 reserved, bits 9..0 row pointer.
// - All registers and the map decode in the upper 32-kbyte external space.
// - Wide words are two bytes: even address low eight, odd low nibble upper four.
// - Reads return written values, except odd map bytes, whose upper four bits read zero, and the status register which shows live state.
module osr_row_map_soft_scroll
  import osr_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic [15:0] ADDR_IN,
  input  wire logic [7:0]  WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [7:0]  RDATA_OUT,
  output logic             RDATA_VALID_OUT,
  input  wire logic        FRAME_START_IN,
  input  wire logic        TEXT_LINE_IN,
  input  wire logic        VSYNC_IN,
  output logic      [9:0]  ROW_PTR_OUT,
  output logic             ROW_TEXT_EN_OUT,
  output logic      [3:0]  ROW_LINE_OUT,
  output logic             ROW_IN_SCROLL_OUT,
  output logic             FRAME_DONE_OUT
);

  osr_map_if map_bus ();

  osr_map_mem #(
    .DEPTH (OSR_MAP_DEPTH),
    .WIDTH (OSR_MAP_WIDTH)
  ) u_map (
    .clk_in   (CLOCK_IN),
    .rst_b_in (RST_B_IN),
    .port     (map_bus.mem)
  );

  // Next scroll row with wrap from the stop row to the start row
  function automatic logic [3:0] wrap_inc(input logic [3:0] cur, input logic [3:0] first, input logic [3:0] last);
    logic [3:0] nxt;
    nxt = (cur == last) ? first : 4'(cur + 4'h1);
    return nxt;
  endfunction

  // Control registers and scroll state
  logic [7:0] area_ctrl_q, area_ctrl_d;
  logic [7:0] range_q,     range_d;
  logic [7:0] aux_q,       aux_d;
  logic       area_en_q,   area_en_d;
  logic       start_q,     start_d;
  logic       pend_q,      pend_d;
  logic [3:0] srow_q,      srow_d;
  logic [3:0] sline_q,     sline_d;
  logic [3:0] top_row;
  logic [3:0] height;
  logic [3:0] first_row;
  logic [3:0] last_row;

  assign top_row   = area_ctrl_q[OSR_TOP_LSB +: 4];
  assign height    = area_ctrl_q[OSR_HEIGHT_LSB +: 4];
  assign first_row = range_q[OSR_FIRST_LSB +: 4];
  assign last_row  = range_q[OSR_LAST_LSB +: 4];

  // Row timing and output state
  logic [3:0] row_q,    row_d;
  logic [3:0] line_q,   line_d;
  logic       done_q,   done_d;
  logic [3:0] dscr_q,   dscr_d;
  logic       in_q,     in_d;
  logic       load_q,   load_d;
  logic [9:0] ptr_q,    ptr_d;
  logic       act_q,    act_d;

  // Read path
  logic        rd_q;
  logic [15:0] raddr_q;
  logic [7:0]  rdata_q, rdata_d;
  logic        rvalid_q;

  logic        upper_space;
  logic        map_hit;

  // Upper space decode
  // upper half decode
  assign upper_space = ADDR_IN[OSR_SPACE_BIT];
  assign map_hit     = upper_space && ADDR_IN >= OSR_MAP_BASE_ADDR && ADDR_IN <= OSR_MAP_LAST_ADDR;

  assign map_bus.bus_we    = WR_IN && map_hit;
  assign map_bus.bus_lo    = !ADDR_IN[0];
  assign map_bus.bus_addr  = ADDR_IN[4:1];
  assign map_bus.bus_wdata = WDATA_IN;

  always_comb begin
    area_ctrl_d = area_ctrl_q;
    range_d     = range_q;
    aux_d       = aux_q;
    area_en_d   = area_en_q;
    start_d     = start_q;
    pend_d      = pend_q;
    srow_d      = srow_q;
    sline_d     = sline_q;
    if (FRAME_START_IN && start_q) begin
      if (sline_q == 4'h0) begin
        srow_d  = pend_q ? first_row : wrap_inc(srow_q, first_row, last_row);
        pend_d  = 1'b0;
        sline_d = OSR_LINE_RELOAD;
        start_d = 1'b0;
      end else begin
        sline_d = 4'(sline_q - 4'h1);
      end
    end
    if (WR_IN && upper_space) begin
      case (ADDR_IN)
        OSR_AREA_CTRL_ADDR: begin
          area_ctrl_d = WDATA_IN;
        end
        OSR_RANGE_ADDR: begin
          range_d = WDATA_IN;
          if (start_q) begin
            pend_d = 1'b1;
          end else begin
            srow_d = WDATA_IN[OSR_FIRST_LSB +: 4];
          end
        end
        OSR_AUX_ADDR: begin
          aux_d = WDATA_IN;
        end
        OSR_STATUS_ADDR: begin
          area_en_d = WDATA_IN[OSR_ST_ENABLE_BIT];
          if (WDATA_IN[OSR_ST_START_BIT]) begin
            start_d = 1'b1;
          end else begin
            start_d = 1'b0;
            pend_d  = 1'b0;
            sline_d = OSR_LINE_RELOAD;
            srow_d  = pend_q ? first_row
                             : wrap_inc(srow_q, first_row, last_row);
          end
        end
        default: begin
          area_ctrl_d = area_ctrl_q;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      area_ctrl_q <= OSR_AREA_CTRL_RST;
      range_q     <= OSR_RANGE_RST;
      aux_q       <= OSR_AUX_RST;
      area_en_q   <= 1'b0;
      start_q     <= 1'b0;
      pend_q      <= 1'b0;
      srow_q      <= 4'h0;
      sline_q     <= OSR_LINE_RELOAD;
    end else begin
      area_ctrl_q <= area_ctrl_d;
      range_q     <= range_d;
      aux_q       <= aux_d;
      area_en_q   <= area_en_d;
      start_q     <= start_d;
      pend_q      <= pend_d;
      srow_q      <= srow_d;
      sline_q     <= sline_d;
    end
  end

  // Row sequencing
  logic       begin_row;
  logic [3:0] nrow;
  logic       in_reg;
  logic [3:0] row_ofs;

  always_comb begin
    row_d     = row_q;
    line_d    = line_q;
    done_d    = done_q;
    dscr_d    = dscr_q;
    in_d      = in_q;
    load_d    = 1'b0;
    ptr_d     = ptr_q;
    act_d     = act_q;
    begin_row = 1'b0;
    nrow      = row_q;
    if (FRAME_START_IN) begin
      nrow      = 4'h0;
      begin_row = 1'b1;
      done_d    = 1'b0;
    end else if (TEXT_LINE_IN && !done_q) begin
      if (line_q == 4'h0) begin
        if (row_q == OSR_ROW_LAST) begin
          done_d = 1'b1;
        end else begin
          nrow      = 4'(row_q + 4'h1);
          begin_row = 1'b1;
        end
      end else begin
        line_d = 4'(line_q - 4'h1);
      end
    end
    if (VSYNC_IN && !FRAME_START_IN) begin
      done_d    = 1'b1;
      begin_row = 1'b0;
    end
    row_ofs = 4'(nrow - top_row);
    in_reg  = area_en_q && (nrow >= top_row) && (row_ofs <= height);
    if (begin_row) begin
      row_d  = nrow;
      in_d   = in_reg;
      load_d = 1'b1;
      line_d = (in_reg && start_q && nrow == top_row) ? sline_q : OSR_LINE_RELOAD;
      if (in_reg) begin
        dscr_d = (nrow == top_row) ? srow_q : wrap_inc(dscr_q, first_row, last_row);
      end
    end
    if (load_q) begin
      ptr_d = map_bus.disp_rdata[OSR_MAP_PTR_MSB:0];
      act_d = in_q || map_bus.disp_rdata[OSR_MAP_EN_BIT];
    end
    if (done_d) begin
      act_d = 1'b0;
    end
  end

  assign map_bus.disp_addr = in_reg ? dscr_d : nrow;

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      row_q  <= 4'h0;
      line_q <= OSR_LINE_RELOAD;
      done_q <= 1'b1;
      dscr_q <= 4'h0;
      in_q   <= 1'b0;
      load_q <= 1'b0;
      ptr_q  <= 10'h000;
      act_q  <= 1'b0;
    end else begin
      row_q  <= row_d;
      line_q <= line_d;
      done_q <= done_d;
      dscr_q <= dscr_d;
      in_q   <= in_d;
      load_q <= load_d;
      ptr_q  <= ptr_d;
      act_q  <= act_d;
    end
  end

  // Register and map read-back
  always_comb begin
    rdata_d = rdata_q;
    if (rd_q) begin
      if (raddr_q >= OSR_MAP_BASE_ADDR && raddr_q <= OSR_MAP_LAST_ADDR) begin
        rdata_d = raddr_q[0] ? {4'h0, map_bus.bus_rdata[11:8]} : map_bus.bus_rdata[7:0];
      end else begin
        case (raddr_q)
          OSR_AREA_CTRL_ADDR: rdata_d = area_ctrl_q;
          OSR_RANGE_ADDR:     rdata_d = range_q;
          OSR_AUX_ADDR:       rdata_d = aux_q;
          OSR_STATUS_ADDR:    rdata_d = {4'h0, in_q, done_q, start_q, area_en_q};
          default:            rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rd_q     <= 1'b0;
      raddr_q  <= 16'h0000;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rd_q     <= RD_IN && upper_space;
      raddr_q  <= ADDR_IN;
      rdata_q  <= rdata_d;
      rvalid_q <= rd_q;
    end
  end

  assign RDATA_OUT         = rdata_q;
  assign RDATA_VALID_OUT   = rvalid_q;
  assign ROW_PTR_OUT       = ptr_q;
  assign ROW_TEXT_EN_OUT   = act_q;
  assign ROW_LINE_OUT      = line_q;
  assign ROW_IN_SCROLL_OUT = in_q;
  assign FRAME_DONE_OUT    = done_q;

endmodule
`default_nettype wire

// File: verilog/osr_pkg.sv
// Constants for the on-screen row map and soft scroll block
`default_nettype none
package osr_pkg;

  // Upper 32-kbyte external data space is the display section
  localparam logic [15:0] OSR_MAP_BASE_ADDR   = 16'h8000;
  localparam logic [15:0] OSR_MAP_LAST_ADDR   = 16'h801F;
  localparam logic [15:0] OSR_AREA_CTRL_ADDR  = 16'h87F6;
  localparam logic [15:0] OSR_RANGE_ADDR      = 16'h87F7;
  localparam logic [15:0] OSR_AUX_ADDR        = 16'h87F8;
  localparam logic [15:0] OSR_STATUS_ADDR     = 16'h87F9;
  localparam int          OSR_SPACE_BIT       = 15;

  // Scroll map word layout
  localparam int          OSR_MAP_WIDTH       = 12;
  localparam int          OSR_MAP_DEPTH       = 16;
  localparam int          OSR_MAP_EN_BIT      = 11;
  localparam int          OSR_MAP_PTR_MSB     = 9;
  localparam int          OSR_HI_NIBBLE_W     = 4;

  // Area control register fields
  localparam int          OSR_TOP_LSB         = 0;
  localparam int          OSR_HEIGHT_LSB      = 4;
  // Range register fields
  localparam int          OSR_FIRST_LSB       = 0;
  localparam int          OSR_LAST_LSB        = 4;
  // Status register fields
  localparam int          OSR_ST_ENABLE_BIT   = 0;
  localparam int          OSR_ST_START_BIT    = 1;
  localparam int          OSR_ST_DONE_BIT     = 2;
  localparam int          OSR_ST_INSCR_BIT    = 3;

  // Reset values
  localparam logic [7:0]  OSR_AREA_CTRL_RST   = 8'h00;
  localparam logic [7:0]  OSR_RANGE_RST       = 8'h00;
  localparam logic [7:0]  OSR_AUX_RST         = 8'h00;

  // Row timing
  localparam logic [3:0]  OSR_LINE_RELOAD     = 4'hC;
  localparam logic [3:0]  OSR_ROW_LAST        = 4'hF;

endpackage
`default_nettype wire

// File: verilog/osr_map_if.sv
// Link between the row controller and the scroll map memory
`timescale 1ns/10ps
`default_nettype none
interface osr_map_if;
  logic        bus_we;
  logic        bus_lo;
  logic [3:0]  bus_addr;
  logic [7:0]  bus_wdata;
  logic [11:0] bus_rdata;
  logic [3:0]  disp_addr;
  logic [11:0] disp_rdata;

  modport ctrl (output bus_we, output bus_lo, output bus_addr, output bus_wdata, input bus_rdata,
                output disp_addr, input disp_rdata);
  modport mem  (input bus_we, input bus_lo, input bus_addr, input bus_wdata, output bus_rdata,
                input disp_addr, output disp_rdata);
endinterface
`default_nettype wire

// File: verilog/osr_map_mem.sv
// Sixteen-word scroll map with byte writes and two registered read ports
`timescale 1ns/10ps
`default_nettype none
module osr_map_mem
  import osr_pkg::*;
#(
  parameter int DEPTH = OSR_MAP_DEPTH,
  parameter int WIDTH = OSR_MAP_WIDTH
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  osr_map_if.mem    port
);

  if (DEPTH != 16 || WIDTH != 12) begin : g_bad
    $error("osr_map_mem supports only 16 words of 12 bits");
  end

  logic [WIDTH-1:0] word_q [DEPTH];
  logic [WIDTH-1:0] word_d [DEPTH];
  logic [WIDTH-1:0] bus_rd_q;
  logic [WIDTH-1:0] disp_rd_q;

  // Even byte loads bits 7..0, odd byte loads bits 11..8 from its low nibble
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_comb begin
      word_d[i] = word_q[i];
      if (port.bus_we && port.bus_addr == 4'(i)) begin
        if (port.bus_lo) begin
          word_d[i][7:0] = port.bus_wdata;
        end else begin
          word_d[i][WIDTH-1:8] = port.bus_wdata[OSR_HI_NIBBLE_W-1:0];
        end
      end
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        word_q[i] <= '0;
      end else begin
        word_q[i] <= word_d[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_rd_q  <= '0;
      disp_rd_q <= '0;
    end else begin
      bus_rd_q  <= word_q[port.bus_addr];
      disp_rd_q <= word_q[port.disp_addr];
    end
  end

  assign port.bus_rdata  = bus_rd_q;
  assign port.disp_rdata = disp_rd_q;

endmodule
`default_nettype wire

// File: bench/osr_row_monitor.sv
// Port checker for the row map and soft scroll block
`timescale 1ns/10ps
`default_nettype none
module osr_row_monitor (
  input wire logic        CLOCK_IN,
  input wire logic        RST_B_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic        RD_IN,
  input wire logic        RDATA_VALID_OUT,
  input wire logic        FRAME_START_IN,
  input wire logic        TEXT_LINE_IN,
  input wire logic        VSYNC_IN,
  input wire logic        ROW_TEXT_EN_OUT,
  input wire logic [3:0]  ROW_LINE_OUT,
  input wire logic        ROW_IN_SCROLL_OUT,
  input wire logic        FRAME_DONE_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);
  a_read_answer_late: assert property (RD_IN && ADDR_IN[15] |-> ##2 RDATA_VALID_OUT)
    else $error("read answer missing");
  a_answer_has_cause: assert property (RDATA_VALID_OUT |-> $past(RD_IN && ADDR_IN[15], 2))
    else $error("read answer without request");
  a_vsync_ends_frame: assert property (VSYNC_IN && !FRAME_START_IN |-> ##[1:2] FRAME_DONE_OUT)
    else $error("sync did not end rows");
  a_frame_opens_rows: assert property (FRAME_START_IN && !VSYNC_IN |-> ##[1:2] !FRAME_DONE_OUT)
    else $error("frame start did not open rows");
  a_done_holds_still: assert property (FRAME_DONE_OUT && !FRAME_START_IN && !$past(FRAME_START_IN)
    |=> FRAME_DONE_OUT)
    else $error("done dropped without frame start");
  a_done_blanks_text: assert property ($rose(FRAME_DONE_OUT) |-> !ROW_TEXT_EN_OUT)
    else $error("text shown after rows ended");
  a_line_count_max: assert property (ROW_LINE_OUT <= 4'hC)
    else $error("line count above twelve");
  a_line_count_step: assert property (TEXT_LINE_IN && !FRAME_DONE_OUT && ROW_LINE_OUT != 4'h0 && !VSYNC_IN
    |-> ##2 ROW_LINE_OUT == $past(ROW_LINE_OUT, 2) - 4'h1)
    else $error("line count did not step down");
  c_read: cover property (RDATA_VALID_OUT);
  c_done: cover property ($rose(FRAME_DONE_OUT));
  c_soft: cover property (ROW_IN_SCROLL_OUT && ROW_LINE_OUT != 4'hC);
endmodule
bind osr_row_map_soft_scroll osr_row_monitor u_mon (.CLOCK_IN, .RST_B_IN, .ADDR_IN, .RD_IN, .RDATA_VALID_OUT,
  .FRAME_START_IN, .TEXT_LINE_IN, .VSYNC_IN, .ROW_TEXT_EN_OUT, .ROW_LINE_OUT, .ROW_IN_SCROLL_OUT, .FRAME_DONE_OUT);
`default_nettype wire

// File: bench/osr_cpu_model.sv
// Processor bus model issuing byte reads and writes
`timescale 1ns/10ps
`default_nettype none
module osr_cpu_model (
  input  wire logic        clk_in,
  input  wire logic [7:0]  rdata_in,
  input  wire logic        valid_in,
  output logic      [15:0] addr_out,
  output logic      [7:0]  wdata_out,
  output logic             wr_out,
  output logic             rd_out
);
  initial begin
    addr_out = 16'h0000;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    v = 1'b0;
    for (int i = 0; i < 3 && v !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
      v = valid_in;
    end
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// File: bench/osr_row_map_soft_scroll_test.sv
// Self-checking bench for the row map and soft scroll block
`timescale 1ns/10ps
`default_nettype none
module osr_row_map_soft_scroll_test
  import osr_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        frame_start = 1'b0;
  logic        text_line = 1'b0;
  logic        vsync = 1'b0;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, rb;
  logic        wr, rd, valid, rv, text_en, in_scroll, done;
  logic [9:0]  row_ptr;
  logic [3:0]  row_line;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          map[16];
  int          top = 0, hf = 0, first = 0, last = 0, en = 0, sbit = 0, scnt = 12, cnt = 0, pend = 0;
  always #12.5 clk = ~clk;
  osr_row_map_soft_scroll dut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .RDATA_VALID_OUT(valid), .FRAME_START_IN(frame_start), .TEXT_LINE_IN(text_line),
    .VSYNC_IN(vsync), .ROW_PTR_OUT(row_ptr), .ROW_TEXT_EN_OUT(text_en), .ROW_LINE_OUT(row_line),
    .ROW_IN_SCROLL_OUT(in_scroll), .FRAME_DONE_OUT(done));
  osr_cpu_model cpu (.clk_in(clk), .rdata_in(rdata), .valid_in(valid), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    cpu.rd(a, rb, rv);
    chk(rv, 1);
    chk(rb, exp);
  endtask
  function automatic int adv(int c);
    return (c == last) ? first : (c + 1) % 16;
  endfunction
  task automatic wrw(input int i, input logic [11:0] v);
    cpu.wr(OSR_MAP_BASE_ADDR + 16'(2 * i), v[7:0]);
    cpu.wr(OSR_MAP_BASE_ADDR + 16'(2 * i + 1), {4'($urandom), v[11:8]});
    map[i] = v;
  endtask
  task automatic stat(input logic [7:0] d);
    cpu.wr(OSR_STATUS_ADDR, d);
    en = d[0];
    if (d[1]) begin
      sbit = 1;
    end else begin
      sbit = 0;
      scnt = 12;
      cnt = pend ? first : adv(cnt);
      pend = 0;
    end
  endtask
  task automatic range(input logic [3:0] f, input logic [3:0] l);
    cpu.wr(OSR_RANGE_ADDR, {l, f});
    first = f;
    last = l;
    if (sbit) pend = 1;
    else cnt = f;
  endtask
  task automatic area(input logic [3:0] t, input logic [3:0] h);
    cpu.wr(OSR_AREA_CTRL_ADDR, {h, t});
    top = t;
    hf = h;
  endtask
  task automatic line();
    @(negedge clk);
    text_line = 1'b1;
    @(negedge clk);
    text_line = 1'b0;
    @(negedge clk);
  endtask
  task automatic walk();
    int cur;
    int idx;
    int ln;
    logic inr;
    @(negedge clk);
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    if (sbit && scnt == 0) begin
      cnt = pend ? first : adv(cnt);
      pend = 0;
      scnt = 12;
      sbit = 0;
    end else if (sbit) begin
      scnt--;
    end
    cur = cnt;
    for (int r = 0; r < 16; r++) begin
      repeat (2) @(negedge clk);
      inr = en && r >= top && r <= top + hf;
      idx = inr ? cur : r;
      ln = (inr && r == top && sbit) ? scnt : OSR_LINE_RELOAD;
      chk(row_line, 12'(ln));
      chk(in_scroll, inr);
      chk(row_ptr, 12'(map[idx] & 1023));
      chk(text_en, inr ? 12'h001 : 12'(map[idx] >> 11));
      chk(done, 0);
      if (inr) cur = adv(cur);
      repeat (ln + 1) line();
    end
    @(negedge clk);
    chk(done, 1);
    chk(text_en, 0);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    void'($urandom(32'h6349));
    chk(done, 1);
    chk(row_line, 12'h00C);
    rdc(OSR_STATUS_ADDR, 8'h04);
    rdc(OSR_AREA_CTRL_ADDR, OSR_AREA_CTRL_RST);
    rdc(OSR_RANGE_ADDR, OSR_RANGE_RST);
    for (int i = 0; i < 16; i++) wrw(i, 12'($urandom) & 12'hBFF);
    for (int i = 0; i < 16; i++) begin
      rdc(OSR_MAP_BASE_ADDR + 16'(2 * i), 8'(map[i]));
      rdc(OSR_MAP_BASE_ADDR + 16'(2 * i + 1), 8'(map[i] >> 8));
    end
    cpu.wr(OSR_AUX_ADDR, 8'h5A);
    rdc(OSR_AUX_ADDR, 8'h5A);
    cpu.wr(16'h87FF, 8'hA5);
    rdc(16'h87FF, 8'h00);
    cpu.rd(16'h0010, rb, rv);
    chk(rv, 0);
    $display("test registers finished");
    walk();
    area(4'h3, 4'h4);
    // range deliberately shorter than the visible height
    range(4'h2, 4'h4);
    rdc(OSR_AREA_CTRL_ADDR, 8'h43);
    stat(8'h01);
    walk();
    $display("test static and scroll area finished");
    range(4'h2, 4'h4);
    walk();
    stat(8'h01);
    walk();
    $display("test hard scroll finished");
    area(4'h1, 4'h2);
    range(4'h5, 4'h9);
    stat(8'h03);
    for (int f = 0; f < 13; f++) begin
      walk();
      if (f == 5) range(4'h7, 4'h9);
      if (f == 5) rdc(OSR_STATUS_ADDR, 8'h07);
    end
    rdc(OSR_STATUS_ADDR, 8'h05);
    wrw(5, 12'h000);
    // region row whose map entry has text disabled
    wrw(8, 12'h155);
    walk();
    $display("test soft scroll finished");
    stat(8'h03);
    walk();
    range(4'h5, 4'h9);
    stat(8'h01);
    walk();
    $display("test stop with pending start row finished");
    @(negedge clk);
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    repeat (3) line();
    chk(done, 0);
    @(negedge clk);
    vsync = 1'b1;
    @(negedge clk);
    vsync = 1'b0;
    @(negedge clk);
    chk(done, 1);
    chk(text_en, 0);
    rb = row_line;
    line();
    chk(row_line, rb);
    $display("test sync stop finished");
    stop_test();
  end
endmodule
`default_nettype wire
